// File: design/lcg_gating.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
module lcg_gating (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          clkEnable,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [lcg_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [lcg_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [lcg_pkg::STRB_W-1:0]    pstrb,
  output logic      [lcg_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [lcg_pkg::NUM_INPUTS-1:0] cellInputs,
  input  wire logic                          chan1TrueSignal,
  output logic      [lcg_pkg::NUM_CHAN-1:0]  chanValue,
  output lcg_pkg::lcg_gates_t                gateOutputs
);

  lcg_pkg::lcg_state_t                state;
  lcg_pkg::lcg_state_t                next_state;
  logic [lcg_pkg::NUM_INPUTS-1:0]     syncInputs;
  logic [lcg_pkg::NUM_CHAN-1:0]       next_chan;
  logic [lcg_pkg::NUM_GATES-1:0]      rawGate;
  logic [lcg_pkg::EN_W-1:0]           gateEnables [lcg_pkg::NUM_GATES];
  logic                               setupPhase;
  logic                               accessPhase;
  logic                               writeLane0;
  logic                               addrMapped;

  // cell inputs are asynchronous to clk, so they are retimed first
  lcg_input_sync i_lcg_input_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .clkEnable (clkEnable),
    .asyncIn   (cellInputs),
    .syncOut   (syncInputs)
  );

  // bus phases
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign writeLane0  = accessPhase & pwrite & pstrb[0] & clkEnable;

  // zero wait: read data and error are prepared in the setup cycle
  assign pready  = accessPhase & clkEnable;
  assign prdata  = state.readData;
  assign pslverr = state.slaveError & accessPhase;

  always_comb
  begin
    case (paddr)
      lcg_pkg::OFF_DATA2_SEL,
      lcg_pkg::OFF_DATA3_SEL,
      lcg_pkg::OFF_DATA4_SEL,
      lcg_pkg::OFF_GATE1_EN,
      lcg_pkg::OFF_GATE2_EN,
      lcg_pkg::OFF_GATE_INVERT,
      lcg_pkg::OFF_STATUS:
      begin
        addrMapped = 1'b1;
      end
      default:
      begin
        addrMapped = 1'b0;
      end
    endcase
  end

  // channel selection: channel 1 direct from chan1TrueSignal, channels 2 to 4 from the retimed inputs
  always_comb
  begin
    next_chan    = '0;
    next_chan[0] = chan1TrueSignal;
    next_chan[1] = syncInputs[state.regs.chan2Source];
    next_chan[2] = syncInputs[state.regs.chan3Source];
    next_chan[3] = syncInputs[state.regs.chan4Source];
  end

  assign gateEnables[0] = state.regs.gate1Enables;
  assign gateEnables[1] = state.regs.gate2Enables;

  // one term vector per gate; inverted form never depends on the true enable
  genvar g;
  genvar c;
  generate
    for (g = 0; g < lcg_pkg::NUM_GATES; g++)
    begin : g_gate
      logic [lcg_pkg::EN_W-1:0] terms;
      for (c = 0; c < lcg_pkg::NUM_CHAN; c++)
      begin : g_chan
        assign terms[c*lcg_pkg::EN_STRIDE+lcg_pkg::EN_TRUE_OFS] =
          next_chan[c] & gateEnables[g][c*lcg_pkg::EN_STRIDE+lcg_pkg::EN_TRUE_OFS];
        assign terms[c*lcg_pkg::EN_STRIDE+lcg_pkg::EN_INV_OFS] =
          ~next_chan[c] & gateEnables[g][c*lcg_pkg::EN_STRIDE+lcg_pkg::EN_INV_OFS];
      end
      // empty enable set gives an OR of zeros
      assign rawGate[g] = (|terms) ^ state.regs.gateInvert[g];
    end
  endgenerate

  always_comb
  begin
    next_state           = state;
    next_state.chanValue = next_chan;
    next_state.gateValue = rawGate;

    if (setupPhase)
    begin
      next_state.readData   = lcg_pkg::RST_WORD;
      next_state.slaveError = ~addrMapped;
      if (!pwrite)
      begin
        case (paddr)
          lcg_pkg::OFF_DATA2_SEL:
          begin
            // upper bits stay zero
            next_state.readData[lcg_pkg::SEL_LSB +: lcg_pkg::SEL_W] = state.regs.chan2Source;
          end
          lcg_pkg::OFF_DATA3_SEL:
          begin
            next_state.readData[lcg_pkg::SEL_LSB +: lcg_pkg::SEL_W] = state.regs.chan3Source;
          end
          lcg_pkg::OFF_DATA4_SEL:
          begin
            next_state.readData[lcg_pkg::SEL_LSB +: lcg_pkg::SEL_W] = state.regs.chan4Source;
          end
          lcg_pkg::OFF_GATE1_EN:
          begin
            next_state.readData[lcg_pkg::EN_LSB +: lcg_pkg::EN_W] = state.regs.gate1Enables;
          end
          lcg_pkg::OFF_GATE2_EN:
          begin
            next_state.readData[lcg_pkg::EN_LSB +: lcg_pkg::EN_W] = state.regs.gate2Enables;
          end
          lcg_pkg::OFF_GATE_INVERT:
          begin
            next_state.readData[lcg_pkg::INV_GATE1_BIT] = state.regs.gateInvert[0];
            next_state.readData[lcg_pkg::INV_GATE2_BIT] = state.regs.gateInvert[1];
          end
          lcg_pkg::OFF_STATUS:
          begin
            // live view: gates and channels as registered last cycle
            next_state.readData[lcg_pkg::STAT_GATE_LSB +: lcg_pkg::NUM_GATES] = state.gateValue;
            next_state.readData[lcg_pkg::STAT_CHAN_LSB +: lcg_pkg::NUM_CHAN]  = state.chanValue;
          end
          default:
          begin
            next_state.readData = lcg_pkg::RST_WORD;
          end
        endcase
      end
    end

    // writes land at the access edge only; lane 0 carries all stored bits
    if (writeLane0)
    begin
      case (paddr)
        lcg_pkg::OFF_DATA2_SEL:
        begin
          next_state.regs.chan2Source = pwdata[lcg_pkg::SEL_LSB +: lcg_pkg::SEL_W];
        end
        lcg_pkg::OFF_DATA3_SEL:
        begin
          next_state.regs.chan3Source = pwdata[lcg_pkg::SEL_LSB +: lcg_pkg::SEL_W];
        end
        lcg_pkg::OFF_DATA4_SEL:
        begin
          next_state.regs.chan4Source = pwdata[lcg_pkg::SEL_LSB +: lcg_pkg::SEL_W];
        end
        lcg_pkg::OFF_GATE1_EN:
        begin
          next_state.regs.gate1Enables = pwdata[lcg_pkg::EN_LSB +: lcg_pkg::EN_W];
        end
        lcg_pkg::OFF_GATE2_EN:
        begin
          next_state.regs.gate2Enables = pwdata[lcg_pkg::EN_LSB +: lcg_pkg::EN_W];
        end
        lcg_pkg::OFF_GATE_INVERT:
        begin
          next_state.regs.gateInvert[0] = pwdata[lcg_pkg::INV_GATE1_BIT];
          next_state.regs.gateInvert[1] = pwdata[lcg_pkg::INV_GATE2_BIT];
        end
        default:
        begin
          // status and unmapped addresses store nothing
          next_state.regs = state.regs;
        end
      endcase
    end
  end

  // arst_n stands for power-on: fields get a known value instead of unknown
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state.regs.chan2Source  <= lcg_pkg::RST_SEL;
      state.regs.chan3Source  <= lcg_pkg::RST_SEL;
      state.regs.chan4Source  <= lcg_pkg::RST_SEL;
      state.regs.gate1Enables <= lcg_pkg::RST_EN;
      state.regs.gate2Enables <= lcg_pkg::RST_EN;
      state.regs.gateInvert   <= lcg_pkg::RST_INV;
      state.readData          <= lcg_pkg::RST_WORD;
      state.slaveError        <= 1'b0;
      state.chanValue         <= '0;
      state.gateValue         <= '0;
    end
    else if (clkEnable)
    begin
      state <= next_state;
    end
  end

  assign chanValue               = state.chanValue;
  assign gateOutputs.gate1Output = state.gateValue[0];
  assign gateOutputs.gate2Output = state.gateValue[1];

endmodule : lcg_gating

// File: design/lcg_input_sync.sv
`timescale 1ns/1ns
module lcg_input_sync (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          clkEnable,
  input  wire logic [lcg_pkg::NUM_INPUTS-1:0] asyncIn,
  output logic      [lcg_pkg::NUM_INPUTS-1:0] syncOut
);

  lcg_pkg::lcg_sync_t state;
  lcg_pkg::lcg_sync_t next_state;

  // stage1 feeds stage2 only; nothing else looks at it
  always_comb
  begin
    next_state        = state;
    next_state.stage1 = asyncIn;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state.stage1 <= lcg_pkg::RST_INPUTS;
      state.stage2 <= lcg_pkg::RST_INPUTS;
    end
    else if (clkEnable)
    begin
      state <= next_state;
    end
  end

  assign syncOut = state.stage2;

endmodule : lcg_input_sync

// File: design/lcg_pkg.sv
package lcg_pkg;

  // bus geometry
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned STRB_W     = 4;

  // register byte offsets, one aligned word each
  localparam logic [11:0] OFF_DATA2_SEL   = 12'h000;
  localparam logic [11:0] OFF_DATA3_SEL   = 12'h004;
  localparam logic [11:0] OFF_DATA4_SEL   = 12'h008;
  localparam logic [11:0] OFF_GATE1_EN    = 12'h00C;
  localparam logic [11:0] OFF_GATE2_EN    = 12'h010;
  localparam logic [11:0] OFF_GATE_INVERT = 12'h014;
  localparam logic [11:0] OFF_STATUS      = 12'h018;

  // field geometry
  localparam int unsigned SEL_W      = 6;
  localparam int unsigned SEL_LSB    = 0;
  localparam int unsigned EN_W       = 8;
  localparam int unsigned EN_LSB     = 0;
  localparam int unsigned NUM_CHAN   = 4;
  localparam int unsigned NUM_GATES  = 2;
  localparam int unsigned NUM_INPUTS = 64;

  // enable layout: channel n (0 based) inverted at 2n, true at 2n+1
  localparam int unsigned EN_INV_OFS  = 0;
  localparam int unsigned EN_TRUE_OFS = 1;
  localparam int unsigned EN_STRIDE   = 2;

  // invert register bits
  localparam int unsigned INV_GATE1_BIT = 0;
  localparam int unsigned INV_GATE2_BIT = 1;

  // status register bits
  localparam int unsigned STAT_GATE_LSB = 0;
  localparam int unsigned STAT_CHAN_LSB = 4;

  // reset values
  localparam logic [5:0]  RST_SEL    = 6'h00;
  localparam logic [7:0]  RST_EN     = 8'h00;
  localparam logic [1:0]  RST_INV    = 2'h0;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [63:0] RST_INPUTS = 64'h0000_0000_0000_0000;

  typedef struct packed {
    logic [SEL_W-1:0]     chan2Source;
    logic [SEL_W-1:0]     chan3Source;
    logic [SEL_W-1:0]     chan4Source;
    logic [EN_W-1:0]      gate1Enables;
    logic [EN_W-1:0]      gate2Enables;
    logic [NUM_GATES-1:0] gateInvert;
  } lcg_regs_t;

  typedef struct packed {
    lcg_regs_t            regs;
    logic [DATA_W-1:0]    readData;
    logic                 slaveError;
    logic [NUM_CHAN-1:0]  chanValue;
    logic [NUM_GATES-1:0] gateValue;
  } lcg_state_t;

  typedef struct packed {
    logic gate2Output;
    logic gate1Output;
  } lcg_gates_t;

  typedef struct packed {
    logic [NUM_INPUTS-1:0] stage1;
    logic [NUM_INPUTS-1:0] stage2;
  } lcg_sync_t;

endpackage : lcg_pkg

// File: verification/lcg_gating_sva.sv
`timescale 1ns/1ns
module lcg_gating_sva (
  input wire logic                         clk,
  input wire logic                         arst_n,
  input wire logic                         clkEnable,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [lcg_pkg::ADDR_W-1:0]   paddr,
  input wire logic [lcg_pkg::DATA_W-1:0]   prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         chan1TrueSignal,
  input wire logic [lcg_pkg::NUM_CHAN-1:0] chanValue,
  input wire lcg_pkg::lcg_gates_t          gateOutputs
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_ready;
    pready == (psel && penable && clkEnable);
  endproperty
  a_ready: assert property (p_ready) else $error("pready not zero wait");

  property p_err_unmapped;
    (psel && !penable && clkEnable && paddr > 12'h018) ##1 (psel && penable) |-> pslverr && prdata == 32'h0;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  property p_err_mapped;
    (psel && !penable && clkEnable && paddr <= 12'h018 && paddr[1:0] == 2'b00) ##1 (psel && penable) |-> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");

  property p_sel_upper;
    psel && penable && !pwrite && paddr <= 12'h008 |-> prdata[31:6] == 26'h0;
  endproperty
  a_sel_upper: assert property (p_sel_upper) else $error("selector upper bits set");

  property p_en_upper;
    psel && penable && !pwrite && (paddr == 12'h00C || paddr == 12'h010) |-> prdata[31:8] == 24'h0;
  endproperty
  a_en_upper: assert property (p_en_upper) else $error("enable upper bits set");

  // read data must not move before the next setup
  property p_hold;
    psel && penable && pready |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("prdata changed after access");

  property p_freeze;
    !clkEnable |=> $stable(chanValue) && $stable(gateOutputs);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");

  property p_chan1;
    clkEnable |=> chanValue[0] == $past(chan1TrueSignal);
  endproperty
  a_chan1: assert property (p_chan1) else $error("channel 1 not registered");
endmodule : lcg_gating_sva

// File: verification/lcg_gating_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin failCount++; $display("ERROR %0t: got %0h exp %0h", $time, (g), (e)); end end
module lcg_gating_tb;
  logic                clk             = 1'b0;
  logic                arst_n          = 1'b0;
  logic                clkEnable       = 1'b1;
  logic                psel            = 1'b0;
  logic                penable         = 1'b0;
  logic                pwrite          = 1'b0;
  logic [11:0]         paddr           = 12'h000;
  logic [31:0]         pwdata          = 32'h0;
  logic [3:0]          pstrb           = 4'hF;
  logic [63:0]         cellInputs      = 64'h0;
  logic                chan1TrueSignal = 1'b0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [3:0]          chanValue;
  lcg_pkg::lcg_gates_t gateOutputs;
  logic [31:0]         rd;
  logic                er;
  logic [7:0]          en;
  int                  failCount       = 0;
  int                  nCompared       = 0;
  logic [7:0]          pat [12]        = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                                           8'h00, 8'h0C, 8'h66, 8'hFF};

  always #10 clk = ~clk;

  lcg_gating i_lcg_gating (.clk(clk), .arst_n(arst_n), .clkEnable(clkEnable), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cellInputs(cellInputs), .chan1TrueSignal(chan1TrueSignal), .chanValue(chanValue),
    .gateOutputs(gateOutputs));

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task chk_rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0, 4'hF);
    `CHK(rd, d)
    `CHK(er, e)
  endtask : chk_rd

  // channel n inverted at 2n, true at 2n+1
  function automatic logic [7:0] terms(input logic [3:0] c);
    for (int n = 0; n < 4; n++)
    begin
      terms[2*n] = ~c[n];
      terms[2*n+1] = c[n];
    end
  endfunction : terms

  task final_report;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) chk_rd(12'(4*i), 32'h0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wr(12'(4*i), 32'hFFFF_FFFF);
      chk_rd(12'(4*i), 32'h0000_003F, 1'b0);
    end
    wr(lcg_pkg::OFF_GATE1_EN, 32'hFFFF_FFFF);
    wr(lcg_pkg::OFF_GATE2_EN, 32'hFFFF_FFFF);
    chk_rd(lcg_pkg::OFF_GATE2_EN, 32'h0000_00FF, 1'b0);
    apb(1'b1, lcg_pkg::OFF_GATE1_EN, 32'h0, 4'hE);
    chk_rd(lcg_pkg::OFF_GATE1_EN, 32'h0000_00FF, 1'b0);
    wr(12'h01C, 32'hFFFF_FFFF);
    chk_rd(12'h01C, 32'h0, 1'b1);
    chk_rd(12'hFFC, 32'h0, 1'b1);
    $display("test registers done");
    wr(lcg_pkg::OFF_DATA2_SEL, 32'h1);
    wr(lcg_pkg::OFF_DATA3_SEL, 32'h2);
    wr(lcg_pkg::OFF_DATA4_SEL, 32'h3);
    wr(lcg_pkg::OFF_GATE_INVERT, 32'h2);
    cellInputs <= 64'h0000_0000_0000_000A;
    repeat (4) @(posedge clk);
    `CHK(chanValue, 4'hA)
    // gate 2 gets nibble-swapped pattern so crossed registers show up
    for (int k = 0; k < 12; k++)
    begin
      en = pat[k];
      wr(lcg_pkg::OFF_GATE1_EN, {24'h0, en});
      wr(lcg_pkg::OFF_GATE2_EN, {24'h0, en[3:0], en[7:4]});
      repeat (2) @(posedge clk);
      `CHK(gateOutputs.gate1Output, |(en & terms(4'hA)))
      `CHK(gateOutputs.gate2Output, ~|({en[3:0], en[7:4]} & terms(4'hA)))
    end
    chk_rd(lcg_pkg::OFF_GATE_INVERT, 32'h0000_0002, 1'b0);
    chk_rd(lcg_pkg::OFF_STATUS, 32'h0000_00A1, 1'b0);
    $display("test gating done");
    wr(lcg_pkg::OFF_DATA2_SEL, 32'h2);
    repeat (2) @(posedge clk);
    `CHK(chanValue, 4'h8)
    clkEnable <= 1'b0;
    chan1TrueSignal <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(chanValue, 4'h8)
    clkEnable <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(chanValue, 4'h9)
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    chk_rd(lcg_pkg::OFF_DATA3_SEL, 32'h0, 1'b0);
    $display("test freeze and reset done");
    final_report;
  end

  initial
  begin
    #100000;
    failCount++;
    final_report;
  end
endmodule : lcg_gating_tb

bind lcg_gating lcg_gating_sva i_lcg_gating_sva (.clk(clk), .arst_n(arst_n), .clkEnable(clkEnable), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan1TrueSignal(chan1TrueSignal), .chanValue(chanValue), .gateOutputs(gateOutputs));
